// ===== flash_prot_params.svh
// constants of the flash protection logic: offsets, fields, reset values
// assumes 24-bit byte addresses and 16-bit fuse words
`ifndef FLASH_PROT_PARAMS_SVH
`define FLASH_PROT_PARAMS_SVH

// ********************************
// fuse register byte offsets
// ********************************
`define OFS_BANK0_WLOCK     24'h0edfb4
`define OFS_BANK1_WLOCK     24'h0edfb6
`define OFS_ACC_DBG_LOCK    24'h0edfb8
`define OFS_DISABLE_CHAIN   24'h0edfbc
`define OFS_REENABLE_CHAIN  24'h0edfbe

// ********************************
// word indices inside the fuse bank
// ********************************
`define IDX_BANK0          3'h0
`define IDX_BANK1          3'h1
`define IDX_ACC            3'h2
`define IDX_DIS            3'h3
`define IDX_REN            3'h4
`define IDX_NONE           3'h7
`define IDX_LAST           3'h4
`define LOAD_END           3'h5

// ********************************
// fields and reset values
// ********************************
`define ACC_LOCK_BIT       0
`define DBG_LOCK_BIT       1
`define BANK0_SECTORS      10
`define BANK1_SECTORS      2
`define DELIVERY_BANK0     16'hffff
`define DELIVERY_BANK1     16'hffff
`define DELIVERY_ACC       16'hacff
`define DELIVERY_DIS       16'hffff
`define DELIVERY_REN       16'hffff
`define VOL_RST            16'h0000
`define TRAP_NUMBER        16'h009b
`define FLASH_LIMIT        24'h080000
`define CTRL_PAGE          16'h0e00

`endif

// ===== flash_prot_pkg.sv
// types shared by the flash protection logic
// assumes flash_prot_params.svh for all numbers
package flash_prot_pkg;

	typedef logic [4:0][15:0] fuse_bank_t;

	typedef enum logic [1:0] {
		PH_LOAD = 2'b01,
		PH_RUN  = 2'b10
	} phase_t;

	// one data access of the cpu or the event controller
	typedef struct packed {
		logic        valid;
		logic        write;
		logic        peripheral_event_transfer;
		logic        dbg;
		logic [23:0] addr;
	} data_req_t;

	// one program or erase request of the sequencer
	typedef struct packed {
		logic       valid;
		logic       bank;
		logic [9:0] sectors;
	} pe_req_t;

endpackage

// ===== lock_chain.sv
// effective access lock and legality of a fuse chain programming
// assumes volatile and nonvolatile copies come from flash_protection_logic
`timescale 1ns/1ps
`include "flash_prot_params.svh"

module lock_chain (
	input  wire logic        acc_locked_in,
	input  wire logic [15:0] vol_dis_in,
	input  wire logic [15:0] vol_ren_in,
	input  wire logic        nv_acc_in,
	input  wire logic        nv_dbg_in,
	input  wire logic [15:0] nv_dis_in,
	input  wire logic [15:0] nv_ren_in,
	input  wire logic [15:0] new_dis_in,
	input  wire logic [15:0] new_ren_in,
	output logic             lock_out,
	output logic             chain_ok_out
);

	logic [16:0] dis_ext;
	logic [15:0] clr_dis;
	logic [15:0] clr_ren;
	logic [15:0] dis_prereq;

	// ********************************
	// effective lock walk
	// ********************************
	// later pairs override earlier ones; sixteen pairs bound the cycles
	always_comb begin
		dis_ext = {1'b1, vol_dis_in};
		lock_out = acc_locked_in;
		for (int x = 0; x < 16; x++) begin
			if (!vol_dis_in[x] && vol_ren_in[x]) begin
				lock_out = 1'b0;
			end
			if (!vol_ren_in[x] && dis_ext[x+1]) begin
				lock_out = acc_locked_in;
			end
		end
	end

	// ********************************
	// programming order check
	// ********************************
	// only bits going 1 to 0 need a prerequisite
	assign clr_dis = nv_dis_in & ~new_dis_in;
	assign clr_ren = nv_ren_in & ~new_ren_in;
	assign dis_prereq = {~nv_ren_in[14:0], ~nv_dbg_in & ~nv_acc_in};
	assign chain_ok_out = ~|(clr_dis & ~dis_prereq) & ~|(clr_ren & nv_dis_in);

endmodule // lock_chain

// ===== flash_protection_logic.sv
// protection logic of the on-chip program flash
// assumes a fuse array with one-cycle registered reads and all requests on core_clk_in
`timescale 1ns/1ps
`include "flash_prot_params.svh"

module flash_protection_logic
	import flash_prot_pkg::*;
(
	input  wire logic        core_clk_in,
	input  wire logic        sys_rst_in,
	input  wire logic [15:0] nv_rd_data_in,
	input  wire logic        fetch_valid_in,
	input  wire logic [23:0] fetch_addr_in,
	input  wire data_req_t   data_req_in,
	input  wire pe_req_t     pe_req_in,
	input  wire logic        prot_start_in,
	input  wire logic [23:0] prot_addr_in,
	input  wire logic [31:0] prot_data_in,
	output logic             nv_rd_en_out,
	output logic [2:0]       nv_rd_idx_out,
	output logic             nv_prog_en_out,
	output logic [2:0]       nv_prog_idx_out,
	output logic [31:0]      nv_prog_data_out,
	output logic             prot_done_out,
	output logic             prot_err_out,
	output logic             pe_ack_out,
	output logic [9:0]       pe_grant_out,
	output logic             write_protect_violation_flag_out,
	output logic             data_ack_out,
	output logic             data_block_out,
	output logic             data_dummy_out,
	output logic             trap_out,
	output logic [15:0]      trap_num_out,
	output logic             debug_enable_out,
	output logic             access_lock_out,
	output logic             loaded_out
);

	// ********************************
	// state
	// ********************************
	typedef struct packed {
		phase_t      phase;
		logic [2:0]  ld_idx;
		fuse_bank_t  vol;
		fuse_bank_t  nv;
		logic        code_flash;
		logic        rd_en;
		logic        prog_en;
		logic [2:0]  prog_idx;
		logic [31:0] prog_data;
		logic        done;
		logic        err;
		logic        pe_ack;
		logic [9:0]  grant;
		logic        write_protect_violation_flag;
		logic        d_ack;
		logic        d_block;
		logic        d_dummy;
		logic        trap;
		logic        dbg_en;
		logic        lock;
		logic        loaded;
		logic [15:0] trap_num;
	} st_t;

	st_t st_r;
	st_t st_nxt;

	logic [2:0]  sp_idx;
	logic        sp_pair;
	fuse_bank_t  cand_nv;
	fuse_bank_t  cand_vol;
	logic        chain_lock;
	logic        chain_ok;
	logic        lock_eff;
	logic        dbg_open;
	logic        sp_refused;
	logic [15:0] prog_hi;
	logic [2:0]  ld_slot;
	logic        load_last;
	logic [9:0]  pe_sel;
	logic [9:0]  pe_open;
	logic        data_guarded;
	logic        flash_hit;
	logic        ctrl_wr_hit;

	// ********************************
	// decode helpers
	// ********************************
	function automatic logic [2:0] idx_of(input logic [23:0] a);
		unique case (a)
			`OFS_BANK0_WLOCK:    idx_of = `IDX_BANK0;
			`OFS_BANK1_WLOCK:    idx_of = `IDX_BANK1;
			`OFS_ACC_DBG_LOCK:   idx_of = `IDX_ACC;
			`OFS_DISABLE_CHAIN:  idx_of = `IDX_DIS;
			`OFS_REENABLE_CHAIN: idx_of = `IDX_REN;
			default:             idx_of = `IDX_NONE;
		endcase
	endfunction

	function automatic logic in_flash(input logic [23:0] a);
		in_flash = (a < `FLASH_LIMIT);
	endfunction

	function automatic logic in_ctrl(input logic [23:0] a);
		in_ctrl = (a[23:8] == `CTRL_PAGE);
	endfunction

	// ********************************
	// candidate fuse contents
	// ********************************
	// low data half goes to the addressed word, high half to its pair word for bank 0 and the disable chain only
	always_comb begin
		sp_idx = idx_of(prot_addr_in);
		sp_pair = (sp_idx == `IDX_BANK0) || (sp_idx == `IDX_DIS);
		cand_nv = st_r.nv;
		cand_vol = st_r.vol;
		if (sp_idx != `IDX_NONE) begin
			cand_nv[sp_idx] = st_r.nv[sp_idx] & prot_data_in[15:0];
			cand_vol[sp_idx] = prot_data_in[15:0];
			if (sp_pair) begin
				cand_nv[sp_idx + 3'h1] = st_r.nv[sp_idx + 3'h1] & prot_data_in[31:16];
				cand_vol[sp_idx + 3'h1] = prot_data_in[31:16];
			end
		end
		// the chain has no temporary unprotection
		cand_vol[`IDX_DIS] = cand_nv[`IDX_DIS];
		cand_vol[`IDX_REN] = cand_nv[`IDX_REN];
	end

	lock_chain u_chain (
		.acc_locked_in (~st_r.vol[`IDX_ACC][`ACC_LOCK_BIT]),
		.vol_dis_in    (st_r.vol[`IDX_DIS]),
		.vol_ren_in    (st_r.vol[`IDX_REN]),
		.nv_acc_in     (st_r.nv[`IDX_ACC][`ACC_LOCK_BIT]),
		.nv_dbg_in     (st_r.nv[`IDX_ACC][`DBG_LOCK_BIT]),
		.nv_dis_in     (st_r.nv[`IDX_DIS]),
		.nv_ren_in     (st_r.nv[`IDX_REN]),
		.new_dis_in    (cand_nv[`IDX_DIS]),
		.new_ren_in    (cand_nv[`IDX_REN]),
		.lock_out      (chain_lock),
		.chain_ok_out  (chain_ok)
	);

	// until the fuses are in, lock everything and keep debug shut
	assign lock_eff = (st_r.phase == PH_LOAD) | chain_lock;
	assign dbg_open = (st_r.phase == PH_RUN) & st_r.vol[`IDX_ACC][`DBG_LOCK_BIT];

	// ********************************
	// set protection and load decode
	// ********************************
	// unknown word or broken chain order: error answer, nothing changes
	assign sp_refused = (sp_idx == `IDX_NONE) | ~chain_ok;
	assign prog_hi = cand_nv[sp_pair ? sp_idx + 3'h1 : sp_idx];
	assign ld_slot = st_r.ld_idx - 3'h1;
	// the last capture and the phase change share one edge
	assign load_last = (st_r.ld_idx == `LOAD_END);

	// ********************************
	// program and erase decode
	// ********************************
	// bank 1 has two sectors; higher request bits are ignored there
	assign pe_sel = pe_req_in.bank ? {8'h00, pe_req_in.sectors[1:0]} : pe_req_in.sectors;
	// a locked sector drops out of the grant and raises the flag
	assign pe_open = pe_req_in.bank ? {8'h00, st_r.vol[`IDX_BANK1][1:0]} : st_r.vol[`IDX_BANK0][9:0];

	// ********************************
	// data path decode
	// ********************************
	// a debug access skips every check only while debug is open
	assign data_guarded = lock_eff & ~(data_req_in.dbg & dbg_open);
	assign flash_hit = in_flash(data_req_in.addr) & (data_req_in.peripheral_event_transfer | ~st_r.code_flash);
	// writes from flash code may reach the control registers
	assign ctrl_wr_hit = in_ctrl(data_req_in.addr) & data_req_in.write & ~st_r.code_flash;

	// ********************************
	// next state
	// ********************************
	always_comb begin
		st_nxt = st_r;
		st_nxt.prog_en = 1'b0;
		st_nxt.done = 1'b0;
		st_nxt.err = 1'b0;
		st_nxt.pe_ack = 1'b0;
		st_nxt.write_protect_violation_flag = 1'b0;
		st_nxt.d_ack = 1'b0;
		st_nxt.d_block = 1'b0;
		st_nxt.d_dummy = 1'b0;
		st_nxt.trap = 1'b0;
		st_nxt.dbg_en = dbg_open;
		st_nxt.lock = lock_eff;

		// fetch tag for the following data accesses
		// an access in the same cycle as a fetch still sees the old tag
		if (fetch_valid_in) begin
			st_nxt.code_flash = in_flash(fetch_addr_in);
		end

		unique case (st_r.phase)
			PH_LOAD: begin
				// read address leads the data by one cycle
				if (st_r.ld_idx != 3'h0) begin
					st_nxt.vol[ld_slot] = nv_rd_data_in;
					st_nxt.nv[ld_slot] = nv_rd_data_in;
				end
				if (load_last) begin
					st_nxt.phase = PH_RUN;
					st_nxt.loaded = 1'b1;
					st_nxt.rd_en = 1'b0;
				end else begin
					st_nxt.ld_idx = st_r.ld_idx + 3'h1;
					st_nxt.rd_en = (st_r.ld_idx != `IDX_LAST);
				end
				if (prot_start_in) begin
					st_nxt.done = 1'b1;
					st_nxt.err = 1'b1;
				end
				if (pe_req_in.valid) begin
					st_nxt.pe_ack = 1'b1;
					st_nxt.grant = 10'h000;
					st_nxt.write_protect_violation_flag = 1'b1;
				end
			end
			PH_RUN: begin
				// no check of the issuing code's region here
				if (prot_start_in) begin
					st_nxt.done = 1'b1;
					if (sp_refused) begin
						st_nxt.err = 1'b1;
					end else begin
						st_nxt.nv = cand_nv;
						st_nxt.vol = cand_vol;
						st_nxt.prog_en = 1'b1;
						st_nxt.prog_idx = sp_idx;
						st_nxt.prog_data = {prog_hi, cand_nv[sp_idx]};
					end
				end
				if (pe_req_in.valid) begin
					st_nxt.pe_ack = 1'b1;
					st_nxt.grant = pe_sel & pe_open;
					st_nxt.write_protect_violation_flag = |(pe_sel & ~pe_open);
				end
			end
		endcase

		// data path check; loading counts as locked
		if (data_req_in.valid) begin
			st_nxt.d_ack = 1'b1;
			if (data_guarded) begin
				// ram or external code reads dummy data; event transfers get no trap
				if (flash_hit) begin
					st_nxt.d_block = 1'b1;
					st_nxt.d_dummy = !data_req_in.write;
					st_nxt.trap = !data_req_in.write && !data_req_in.peripheral_event_transfer;
				end
				if (ctrl_wr_hit) begin
					st_nxt.d_block = 1'b1;
				end
			end
		end
	end

	// ********************************
	// registers
	// ********************************
	// volatile copies reset to zero: every lock active until load
	always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			st_r.phase <= PH_LOAD;
			st_r.ld_idx <= 3'h0;
			st_r.vol <= {5{`VOL_RST}};
			st_r.nv <= {5{`VOL_RST}};
			st_r.code_flash <= 1'b0;
			st_r.rd_en <= 1'b1;
			st_r.prog_en <= 1'b0;
			st_r.prog_idx <= 3'h0;
			st_r.prog_data <= 32'h0000_0000;
			st_r.done <= 1'b0;
			st_r.err <= 1'b0;
			st_r.pe_ack <= 1'b0;
			st_r.grant <= 10'h000;
			st_r.write_protect_violation_flag <= 1'b0;
			st_r.d_ack <= 1'b0;
			st_r.d_block <= 1'b0;
			st_r.d_dummy <= 1'b0;
			st_r.trap <= 1'b0;
			st_r.dbg_en <= 1'b0;
			st_r.lock <= 1'b1;
			st_r.loaded <= 1'b0;
			st_r.trap_num <= `TRAP_NUMBER;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ********************************
	// outputs
	// ********************************
	assign nv_rd_en_out = st_r.rd_en;
	assign nv_rd_idx_out = st_r.ld_idx;
	assign nv_prog_en_out = st_r.prog_en;
	assign nv_prog_idx_out = st_r.prog_idx;
	assign nv_prog_data_out = st_r.prog_data;
	assign prot_done_out = st_r.done;
	assign prot_err_out = st_r.err;
	assign pe_ack_out = st_r.pe_ack;
	assign pe_grant_out = st_r.grant;
	assign write_protect_violation_flag_out = st_r.write_protect_violation_flag;
	assign data_ack_out = st_r.d_ack;
	assign data_block_out = st_r.d_block;
	assign data_dummy_out = st_r.d_dummy;
	assign trap_out = st_r.trap;
	// constant, but kept in a flop like every other output
	assign trap_num_out = st_r.trap_num;
	assign debug_enable_out = st_r.dbg_en;
	assign access_lock_out = st_r.lock;
	assign loaded_out = st_r.loaded;

endmodule // flash_protection_logic

// ===== flash_prot_monitor.sv
// assertions on the ports of the flash protection logic
// assumes it is bound onto flash_protection_logic
`timescale 1ns/1ps
`include "flash_prot_params.svh"

module flash_prot_monitor
	import flash_prot_pkg::*;
(
	input wire logic        core_clk_in,
	input wire logic        sys_rst_in,
	input wire data_req_t   data_req_in,
	input wire pe_req_t     pe_req_in,
	input wire logic        prot_start_in,
	input wire logic        nv_prog_en_out,
	input wire logic        prot_done_out,
	input wire logic        prot_err_out,
	input wire logic        pe_ack_out,
	input wire logic [9:0]  pe_grant_out,
	input wire logic        write_protect_violation_flag_out,
	input wire logic        data_ack_out,
	input wire logic        data_block_out,
	input wire logic        data_dummy_out,
	input wire logic        trap_out,
	input wire logic [15:0] trap_num_out,
	input wire logic        debug_enable_out,
	input wire logic        access_lock_out,
	input wire logic        loaded_out
);
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (sys_rst_in);

	prot_answer_a: assert property (prot_start_in |=> prot_done_out)
		else $error("set protection not answered");
	prog_accepted_a: assert property (nv_prog_en_out |-> prot_done_out && !prot_err_out)
		else $error("fuse programmed on a refused request");
	grant_subset_a: assert property (pe_ack_out |-> (pe_grant_out & ~$past(pe_req_in.sectors)) == 10'h000)
		else $error("grant beyond requested sectors");
	violation_cause_a: assert property (write_protect_violation_flag_out |-> pe_ack_out)
		else $error("violation flag without answer");
	pe_answer_a: assert property (pe_req_in.valid |=> pe_ack_out)
		else $error("program request not answered");
	data_answer_a: assert property (data_req_in.valid |=> data_ack_out)
		else $error("data access not answered");
	trap_cause_a: assert property (trap_out |-> data_block_out && data_dummy_out && !$past(data_req_in.write))
		else $error("trap without blocked read");
	trap_number_a: assert property (trap_out |-> trap_num_out == `TRAP_NUMBER)
		else $error("wrong trap number");
	load_locked_a: assert property (!loaded_out |-> access_lock_out && !debug_enable_out)
		else $error("protection open before load");
endmodule // flash_prot_monitor

bind flash_protection_logic flash_prot_monitor mon (.core_clk_in, .sys_rst_in, .data_req_in, .pe_req_in,
	.prot_start_in, .nv_prog_en_out, .prot_done_out, .prot_err_out, .pe_ack_out, .pe_grant_out,
	.write_protect_violation_flag_out, .data_ack_out, .data_block_out, .data_dummy_out, .trap_out,
	.trap_num_out, .debug_enable_out, .access_lock_out, .loaded_out);

// ===== fuse_array_model.sv
// behavioural fuse array with registered read
// assumes index and program pulses from flash_protection_logic
`timescale 1ns/1ps
`include "flash_prot_params.svh"

module fuse_array_model
	import flash_prot_pkg::*;
(
	input  wire logic        core_clk_in,
	input  wire logic        rd_en_in,
	input  wire logic [2:0]  rd_idx_in,
	input  wire logic        prog_en_in,
	input  wire logic [2:0]  prog_idx_in,
	input  wire logic [31:0] prog_data_in,
	output logic      [15:0] rd_data_out
);
	fuse_bank_t fuse_r;

	// fuses keep their state across reset, so no reset here
	initial begin
		fuse_r = {`DELIVERY_REN, `DELIVERY_DIS, `DELIVERY_ACC, `DELIVERY_BANK1, `DELIVERY_BANK0};
		rd_data_out = 16'h0000;
	end

	always @(posedge core_clk_in) begin
		// idle read port shows garbage, not the last word
		rd_data_out <= (rd_en_in && rd_idx_in <= `IDX_LAST) ? fuse_r[rd_idx_in] : ~rd_data_out;
		if (prog_en_in) begin
			fuse_r[prog_idx_in] <= fuse_r[prog_idx_in] & prog_data_in[15:0];
			if (prog_idx_in == `IDX_BANK0 || prog_idx_in == `IDX_DIS) begin
				fuse_r[prog_idx_in + 3'h1] <= fuse_r[prog_idx_in + 3'h1] & prog_data_in[31:16];
			end
		end
	end
endmodule // fuse_array_model

// ===== tb.sv
// self-checking bench of the flash protection logic
// assumes fuse_array_model as the fuse array
`timescale 1ns/1ps

module tb
	import flash_prot_pkg::*;
;
	logic        core_clk_in = 1'b0;
	logic        sys_rst_in = 1'b1;
	logic        fetch_valid_in = 1'b1;
	logic        prot_start_in = 1'b0;
	logic [23:0] fetch_addr_in = 24'h100000;
	logic [23:0] prot_addr_in = 24'h000000;
	logic [31:0] prot_data_in = 32'h00000000;
	data_req_t   data_req_in = '0;
	pe_req_t     pe_req_in = '0;
	logic [15:0] nv_rd_data_in, trap_num_out;
	logic [2:0]  nv_rd_idx_out, nv_prog_idx_out;
	logic [31:0] nv_prog_data_out;
	logic [9:0]  pe_grant_out;
	logic        nv_rd_en_out, nv_prog_en_out, prot_done_out, prot_err_out, pe_ack_out;
	logic        write_protect_violation_flag_out, data_ack_out, data_block_out, data_dummy_out;
	logic        trap_out, debug_enable_out, access_lock_out, loaded_out;
	int          failures = 0;
	int          checked = 0;

	always #2.5 core_clk_in = ~core_clk_in;

	flash_protection_logic uut (.core_clk_in, .sys_rst_in, .nv_rd_data_in, .fetch_valid_in, .fetch_addr_in,
		.data_req_in, .pe_req_in, .prot_start_in, .prot_addr_in, .prot_data_in, .nv_rd_en_out, .nv_rd_idx_out,
		.nv_prog_en_out, .nv_prog_idx_out, .nv_prog_data_out, .prot_done_out, .prot_err_out, .pe_ack_out,
		.pe_grant_out, .write_protect_violation_flag_out, .data_ack_out, .data_block_out, .data_dummy_out,
		.trap_out, .trap_num_out, .debug_enable_out, .access_lock_out, .loaded_out);

	fuse_array_model part (.core_clk_in, .rd_en_in(nv_rd_en_out), .rd_idx_in(nv_rd_idx_out),
		.prog_en_in(nv_prog_en_out), .prog_idx_in(nv_prog_idx_out), .prog_data_in(nv_prog_data_out),
		.rd_data_out(nv_rd_data_in));

	// ********
	// helpers
	// ********
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			failures++;
			$display("ERROR t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic final_report();
		$display("checked %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic tk();
		@(posedge core_clk_in);
		#1;
	endtask

	task automatic do_reset();
		sys_rst_in = 1'b1;
		repeat (8) tk();
		chk({access_lock_out, debug_enable_out, loaded_out}, 3'b100);
		sys_rst_in = 1'b0;
		for (int i = 0; i < 20 && loaded_out !== 1'b1; i++) tk();
		repeat (2) tk();
	endtask

	// second edge lets the new lock state land
	task automatic prot(input logic [23:0] a, input logic [31:0] d, input logic e);
		prot_start_in = 1'b1;
		prot_addr_in = a;
		prot_data_in = d;
		tk();
		prot_start_in = 1'b0;
		chk({prot_done_out, prot_err_out}, {1'b1, e});
		tk();
	endtask

	task automatic pe(input logic b, input logic [9:0] s, input logic [9:0] g, input logic w);
		pe_req_in = '{1'b1, b, s};
		tk();
		pe_req_in = '0;
		chk({pe_ack_out, write_protect_violation_flag_out, pe_grant_out}, {1'b1, w, g});
		tk();
	endtask

	// e = block, dummy, trap
	task automatic dat(input logic [23:0] a, input logic w, input logic p, input logic g, input logic [2:0] e);
		data_req_in = '{1'b1, w, p, g, a};
		tk();
		data_req_in = '0;
		chk({data_ack_out, data_block_out, data_dummy_out, trap_out, trap_num_out}, {1'b1, e, 16'h009b});
		tk();
	endtask

	task automatic fe(input logic [23:0] a);
		fetch_addr_in = a;
		tk();
	endtask

	// ********
	// scenarios
	// ********
	task automatic t_load();
		do_reset();
		chk({access_lock_out, debug_enable_out}, 2'b01);
	endtask

	task automatic t_write_lock();
		pe(1'b0, 10'h3ff, 10'h3ff, 1'b0);
		prot(24'h0edfb4, 32'hfffefffe, 1'b0);
		pe(1'b0, 10'h3ff, 10'h3fe, 1'b1);
		pe(1'b1, 10'h003, 10'h002, 1'b1);
		prot(24'h0edfba, 32'h00000000, 1'b1);
		prot(24'h0edfb4, 32'hffffffff, 1'b0);
		pe(1'b0, 10'h001, 10'h001, 1'b0);
		chk({16'h0000, part.fuse_r[0]}, 32'h0000fffe);
		prot(24'h0edfb4, 32'hfffefffe, 1'b0);
		pe(1'b0, 10'h001, 10'h000, 1'b1);
	endtask

	task automatic t_access();
		prot(24'h0edfbc, 32'hfffffffe, 1'b1);
		prot(24'h0edfb8, 32'h0000fffe, 1'b0);
		chk({access_lock_out, debug_enable_out}, 2'b11);
		dat(24'h001000, 1'b0, 1'b0, 1'b1, 3'b000);
		dat(24'h001000, 1'b0, 1'b0, 1'b0, 3'b111);
		dat(24'h001000, 1'b1, 1'b0, 1'b0, 3'b100);
		dat(24'h001000, 1'b0, 1'b1, 1'b0, 3'b110);
		dat(24'h0e0010, 1'b1, 1'b0, 1'b0, 3'b100);
		dat(24'h0e0010, 1'b0, 1'b0, 1'b0, 3'b000);
		dat(24'h200000, 1'b0, 1'b0, 1'b0, 3'b000);
		fe(24'h002000);
		dat(24'h001000, 1'b0, 1'b0, 1'b0, 3'b000);
		dat(24'h0e0010, 1'b1, 1'b0, 1'b0, 3'b000);
		fetch_valid_in = 1'b0;
		fe(24'h100000);
		dat(24'h001000, 1'b1, 1'b0, 1'b0, 3'b000);
		fetch_valid_in = 1'b1;
		fe(24'h100000);
		prot(24'h0edfb8, 32'h0000fffc, 1'b0);
		chk({access_lock_out, debug_enable_out}, 2'b10);
		dat(24'h001000, 1'b0, 1'b0, 1'b1, 3'b111);
	endtask

	task automatic t_chain();
		prot(24'h0edfbe, 32'h0000fffe, 1'b1);
		prot(24'h0edfbc, 32'hfffffffd, 1'b1);
		prot(24'h0edfbc, 32'hfffffffe, 1'b0);
		chk(access_lock_out, 1'b0);
		dat(24'h001000, 1'b0, 1'b0, 1'b0, 3'b000);
		prot(24'h0edfbc, 32'hfffffffd, 1'b1);
		prot(24'h0edfbe, 32'h0000fffe, 1'b0);
		chk(access_lock_out, 1'b1);
		dat(24'h001000, 1'b0, 1'b0, 1'b0, 3'b111);
		prot(24'h0edfbc, 32'hfffffffc, 1'b0);
		chk(access_lock_out, 1'b0);
	endtask

	task automatic t_reload();
		prot(24'h0edfb4, 32'hffffffff, 1'b0);
		do_reset();
		chk({access_lock_out, debug_enable_out}, 2'b00);
		pe(1'b0, 10'h3ff, 10'h3fe, 1'b1);
	endtask

	initial begin
		t_load();
		t_write_lock();
		t_access();
		t_chain();
		t_reload();
		final_report();
	end

	// the whole run needs well under a thousand cycles
	initial begin
		#20000;
		failures++;
		final_report();
	end
endmodule // tb
